// ===== rst_ctl_pkg.sv
// Constants for the reset and external interrupt controller
package rst_ctl_pkg;
	localparam int CLK_PERIOD_NS = 20;
	// Times in CPU clock periods (P) or memory-interface clock periods (E)
	localparam int BOOT_HOLD_P     = 4;
	localparam int ZGRP_MIN_P      = 2;
	localparam int ZGRP_MAX_P      = 8;
	localparam int EE_MAX_P        = 11;
	localparam int MEMIF_FLOAT_E   = 2;
	localparam int MEMIF_VALID_E   = 16;
	// One P is one core_clk period
	localparam int BOOT_HOLD_CYC   = BOOT_HOLD_P;
	localparam int ZGRP_VALID_CYC  = (ZGRP_MIN_P + ZGRP_MAX_P) / 2;
	localparam int EE_VALID_CYC    = EE_MAX_P - 1;
	localparam int WARM_RESET_CYC  = 16;
	localparam int REL_CNT_MAX     = 15;
	localparam int E_CNT_MAX       = 31;
	localparam logic [4:0] MEMIF_FLOAT_CNT = 5'(MEMIF_FLOAT_E);
	localparam logic [4:0] MEMIF_VALID_CNT = 5'(MEMIF_VALID_E);
	localparam logic [3:0] ZGRP_VALID_CNT  = 4'(ZGRP_VALID_CYC);
	localparam logic [3:0] EE_VALID_CNT    = 4'(EE_VALID_CYC);
	localparam logic [3:0] BOOT_HOLD_CNT   = 4'(BOOT_HOLD_CYC - 1);
	localparam logic [4:0] WARM_CNT_INIT   = 5'(WARM_RESET_CYC);
	// Register byte offsets
	localparam logic [7:0] POL_OFFSET      = 8'h00;
	localparam logic [7:0] STATUS_OFFSET   = 8'h04;
	localparam logic [7:0] CTRL_OFFSET     = 8'h08;
	localparam logic [3:0] POL_RESET       = 4'hf;
	localparam int CTRL_EMU_BIT            = 0;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;
	typedef enum logic [1:0] {ST_RESET, ST_CAPTURE, ST_RUN} seq_state_e;
endpackage

// ===== rst_ctl.sv
// Reset sequencer, boot strap latch and external interrupt detector
`timescale 1ns/1ns
// Summary of operation
// RQ1 - Source holds non-maskable interrupt low and high at least four periods each.
// RQ2 - Source holds each external interrupt low and high at least eight periods.
// RQ3 - Defined state is reached only through asserted active-low hardware reset.
// RQ4 - Board holds hardware reset low at least 250 microseconds.
// RQ5 - Core reference clock runs at its intended rate before reset release.
// RQ6 - With PCI enabled, PCI clock runs 32 periods before reset release.
// RQ7 - Host warm reset, PCI only, resets like hardware but keeps latched boot settings.
// RQ8 - Hardware reset leaves PCI state machine alone; only PCI-side reset clears it.
// RQ9 - PCI-side reset has no effect on core or other logic.
// RQ10 - Emulation reset behaves exactly like host warm reset.
// RQ11 - Straps sampled at hardware reset release; held valid four periods after.
// RQ12 - Memory clock resynchronised within 2E to 3P+20E and 2E to 8P+20E.
// RQ13 - Memory clock output floats after 2E, valid by 8P+20E after release.
// RQ14 - Memory bus outputs float 2E..3P+4E after assertion, valid 16E..8P+20E.
// RQ15 - Hold acknowledge and bus request follow; hold acknowledge mirrors hold request.
// RQ16 - EEPROM pins invalid at assertion, valid within 11 periods after release.
// RQ17 - EEPROM pins drive in reset only with PCI on and serial port 2 off.
// RQ18 - Host, PCI, video, GPIO, timer outputs float, valid 2 to 8 periods later.
// RQ19 - PCI enable strap is driven valid and constant throughout operation.
// RQ20 - External strap drivers avoid contention with device float timing.
// RQ21 - External interrupt active level is chosen by a software polarity register.
// RQ22 - Interrupt inputs pass two flip-flops; edges found on synchronised values.
// RQ23 - Reset input is synchronised; internal reset releases after straps captured.
module rst_ctl
	import rst_ctl_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        hw_reset_n,
	input  wire logic        host_soft_reset,
	input  wire logic        pci_side_reset_in,
	input  wire logic        pci_enable_strap,
	input  wire logic        serial_port2_enable_strap,
	input  wire logic [3:0]  boot_address_straps,
	input  wire logic        endian_strap,
	input  wire logic        pci_eeprom_autoinit_strap,
	input  wire logic        host_width_strap,
	input  wire logic        memif_ref_clock,
	input  wire logic        hold_request_in,
	input  wire logic        core_hold_ack,
	input  wire logic        core_bus_req,
	input  wire logic        nmi_in,
	input  wire logic [3:0]  external_irq_in,
	output logic             core_reset_out,
	output logic             pci_sm_reset_out,
	output logic [3:0]       boot_address_out,
	output logic             endian_out,
	output logic             pci_eeprom_autoinit_out,
	output logic             host_width_out,
	output logic             memif_clock_synced,
	output logic             memif_group_oe,
	output logic             hold_acknowledge_out,
	output logic             bus_request_out,
	output logic             eeprom_select_oe,
	output logic             eeprom_pins_oe,
	output logic             eeprom_valid,
	output logic             zgroup_oe,
	output logic             nmi_event,
	output logic [3:0]       irq_event,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	seq_state_e  state_reg, state_next;
	logic        rst_s1_reg, rst_s2_reg;
	logic [4:0]  irq_s1_reg, irq_s2_reg, irq_s3_reg;
	logic        eclk_q_reg;
	logic        hw_cause_reg, hw_cause_next;
	logic [4:0]  warm_cnt_reg, warm_cnt_next;
	logic [3:0]  rel_cnt_reg, rel_cnt_next;
	logic [4:0]  e_cnt_reg, e_cnt_next;
	logic [6:0]  boot_reg, boot_next;
	logic        hold_ack_reg, hold_ack_next, bus_req_reg, bus_req_next;
	logic [4:0]  event_reg, event_next;
	logic        pci_rst_reg;
	logic [3:0]  pol_reg, pol_next;
	logic        emu_req_reg, emu_req_next;
	logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        e_tick, warm_req, reset_req, released, wr_go, rd_go;
	logic [4:0]  active_lvl;
	default clocking assert_cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	// Memory-interface clock rising edges give the E time base
	assign e_tick    = memif_ref_clock & ~eclk_q_reg;
	// Warm resets exist only while PCI is enabled
	assign warm_req  = pci_enable_strap & (host_soft_reset | emu_req_reg); // see RQ7 see RQ10
	assign reset_req = ~rst_s2_reg | (warm_cnt_reg != 5'h0); // see RQ23
	assign released  = (state_reg != ST_RESET);

	always_comb begin
		state_next    = state_reg;
		hw_cause_next = hw_cause_reg;
		warm_cnt_next = warm_cnt_reg;
		rel_cnt_next  = rel_cnt_reg;
		e_cnt_next    = e_cnt_reg;
		boot_next     = boot_reg;
		if (warm_req) begin
			warm_cnt_next = WARM_CNT_INIT;
		end else if (warm_cnt_reg != 5'h0) begin
			warm_cnt_next = warm_cnt_reg - 5'h1;
		end
		if (rel_cnt_reg != 4'(REL_CNT_MAX)) begin
			rel_cnt_next = rel_cnt_reg + 4'h1;
		end
		if (e_tick && e_cnt_reg != 5'(E_CNT_MAX)) begin
			e_cnt_next = e_cnt_reg + 5'h1;
		end
		if (~rst_s2_reg) begin
			hw_cause_next = 1'b1;
		end
		case (state_reg)
			ST_RESET: begin
				if (!reset_req) begin
					state_next   = ST_CAPTURE;
					rel_cnt_next = 4'h0;
					e_cnt_next   = 5'h0;
					// Only a hardware release relatches the straps
					if (hw_cause_reg) begin
						boot_next = {boot_address_straps, endian_strap,
							pci_eeprom_autoinit_strap, host_width_strap}; // see RQ11 see RQ7
					end
				end
			end
			ST_CAPTURE: begin
				hw_cause_next = ~rst_s2_reg;
				if (reset_req) begin
					state_next = ST_RESET;
					e_cnt_next = 5'h0;
				end else if (rel_cnt_reg == BOOT_HOLD_CNT) begin
					state_next = ST_RUN; // see RQ23
				end
			end
			default: begin
				if (reset_req) begin
					state_next = ST_RESET;
					e_cnt_next = 5'h0;
				end
			end
		endcase
	end

	always_comb begin
		hold_ack_next = core_hold_ack;
		bus_req_next  = core_bus_req;
		if (state_reg != ST_RUN) begin
			hold_ack_next = hold_request_in; // see RQ15
			bus_req_next  = 1'b0;
		end
		// Polarity bit 1 selects rising edges, 0 falling; NMI is rising only
		active_lvl = {1'b1, pol_reg}; // see RQ21
		for (int i = 0; i < 5; i++) begin
			event_next[i] = (irq_s2_reg[i] != irq_s3_reg[i]) &&
				(irq_s2_reg[i] == active_lvl[i]); // see RQ22 see RQ1 see RQ2
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg    <= ST_RESET;
			rst_s1_reg   <= 1'b0;
			rst_s2_reg   <= 1'b0;
			irq_s1_reg   <= 5'h0;
			irq_s2_reg   <= 5'h0;
			irq_s3_reg   <= 5'h0;
			eclk_q_reg   <= 1'b0;
			hw_cause_reg <= 1'b1;
			warm_cnt_reg <= 5'h0;
			rel_cnt_reg  <= 4'h0;
			e_cnt_reg    <= 5'h0;
			boot_reg     <= 7'h0;
			hold_ack_reg <= 1'b0;
			bus_req_reg  <= 1'b0;
			event_reg    <= 5'h0;
			pci_rst_reg  <= 1'b1;
		end else begin
			state_reg    <= state_next;
			rst_s1_reg   <= hw_reset_n;
			rst_s2_reg   <= rst_s1_reg;
			irq_s1_reg   <= {nmi_in, external_irq_in};
			irq_s2_reg   <= irq_s1_reg;
			irq_s3_reg   <= irq_s2_reg;
			eclk_q_reg   <= memif_ref_clock;
			hw_cause_reg <= hw_cause_next;
			warm_cnt_reg <= warm_cnt_next;
			rel_cnt_reg  <= rel_cnt_next;
			e_cnt_reg    <= e_cnt_next;
			boot_reg     <= boot_next;
			hold_ack_reg <= hold_ack_next;
			bus_req_reg  <= bus_req_next;
			event_reg    <= event_next;
			// The PCI state machine sees only its own reset pin
			pci_rst_reg  <= pci_side_reset_in; // see RQ8 see RQ9
		end
	end

	assign core_reset_out          = (state_reg != ST_RUN); // see RQ3
	assign pci_sm_reset_out        = pci_rst_reg;
	assign {boot_address_out, endian_out, pci_eeprom_autoinit_out, host_width_out} = boot_reg;
	assign nmi_event               = event_reg[4];
	assign irq_event               = event_reg[3:0];
	assign hold_acknowledge_out    = hold_ack_reg;
	assign bus_request_out         = bus_req_reg;
	// Memory side floats after two E edges and returns sixteen E edges after release
	assign memif_group_oe = released ? (e_cnt_reg >= MEMIF_VALID_CNT)
		: (e_cnt_reg < MEMIF_FLOAT_CNT); // see RQ13 see RQ14 see RQ15
	assign memif_clock_synced = (e_cnt_reg >= MEMIF_FLOAT_CNT); // see RQ12
	assign zgroup_oe = released && (rel_cnt_reg >= ZGRP_VALID_CNT); // see RQ18
	assign eeprom_valid = released && (rel_cnt_reg >= EE_VALID_CNT); // see RQ16
	// Straps are constant, so this selection cannot glitch in operation
	assign eeprom_select_oe = (pci_enable_strap && !serial_port2_enable_strap) || zgroup_oe;
	assign eeprom_pins_oe   = eeprom_select_oe; // see RQ17 see RQ19

	// Register slave: address and data are taken together, one at a time
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign rd_go         = s_axi_arvalid && !rvalid_reg;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	always_comb begin
		pol_next     = pol_reg;
		emu_req_next = 1'b0;
		bvalid_next  = bvalid_reg && !s_axi_bready;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg && !s_axi_rready;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		if (wr_go) begin
			bvalid_next = 1'b1;
			bresp_next  = RESP_OKAY;
			if (s_axi_awaddr == POL_OFFSET) begin
				if (s_axi_wstrb[0]) begin
					pol_next = s_axi_wdata[3:0];
				end
			end else if (s_axi_awaddr == CTRL_OFFSET) begin
				emu_req_next = s_axi_wstrb[0] && s_axi_wdata[CTRL_EMU_BIT]; // see RQ10
			end else if (s_axi_awaddr != STATUS_OFFSET) begin
				bresp_next = RESP_SLVERR;
			end
		end
		if (rd_go) begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			rdata_next  = 32'h0;
			if (s_axi_araddr == POL_OFFSET) begin
				rdata_next[3:0] = pol_reg;
			end else if (s_axi_araddr == STATUS_OFFSET) begin
				rdata_next[10:0] = {pci_sm_reset_out, hw_cause_reg, core_reset_out,
					pci_enable_strap, boot_reg};
			end else if (s_axi_araddr != CTRL_OFFSET) begin
				rresp_next = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pol_reg     <= POL_RESET;
			emu_req_reg <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= RESP_OKAY;
			rdata_reg   <= 32'h0;
		end else begin
			pol_reg     <= pol_next;
			emu_req_reg <= emu_req_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
		end
	end

	property p_warm_keeps_boot;
		state_reg == ST_RESET && !hw_cause_reg |=> $stable(boot_reg);
	endproperty
	a_warm_keeps_boot: assert property (p_warm_keeps_boot) else $error("boot relatched"); // see RQ7
	property p_emu_reset;
		// Counter loads one edge after the request, the state follows one edge later
		emu_req_reg && pci_enable_strap |-> ##2 core_reset_out [*8];
	endproperty
	a_emu_reset: assert property (p_emu_reset) else $error("emulation reset too short"); // see RQ10
	property p_pci_isolated;
		state_reg == ST_RUN && rst_s2_reg && warm_cnt_reg == 5'h0 && !warm_req
			&& $changed(pci_side_reset_in) |=> state_reg == ST_RUN;
	endproperty
	a_pci_isolated: assert property (p_pci_isolated) else $error("PCI reset hit core"); // see RQ9
	property p_pci_sm;
		$rose(rst_s2_reg) ##1 1'b1 |-> pci_sm_reset_out == $past(pci_side_reset_in);
	endproperty
	a_pci_sm: assert property (p_pci_sm) else $error("PCI reset tied to hardware reset"); // see RQ8
	property p_strap_latch;
		state_reg == ST_RESET && hw_cause_reg && !reset_req
			|=> boot_reg == $past({boot_address_straps, endian_strap,
			pci_eeprom_autoinit_strap, host_width_strap});
	endproperty
	a_strap_latch: assert property (p_strap_latch) else $error("straps not captured"); // see RQ11
	property p_release;
		$fell(core_reset_out) |-> $past(state_reg == ST_CAPTURE, 4);
	endproperty
	a_release: assert property (p_release) else $error("core released early"); // see RQ23
	property p_zgroup;
		$rose(zgroup_oe) |-> $past(released, 4) && $past(released, 1);
	endproperty
	a_zgroup: assert property (p_zgroup) else $error("Z group timing wrong"); // see RQ18
	property p_eeprom;
		state_reg == ST_CAPTURE && rel_cnt_reg == 4'h0 && !reset_req
			##1 !reset_req [*8] |-> ##[1:2] eeprom_valid;
	endproperty
	a_eeprom: assert property (p_eeprom) else $error("EEPROM group late"); // see RQ16
	property p_memif_float;
		state_reg == ST_RESET && e_cnt_reg >= MEMIF_FLOAT_CNT |-> !memif_group_oe;
	endproperty
	a_memif_float: assert property (p_memif_float) else $error("memory bus driven"); // see RQ14
	property p_hold;
		state_reg != ST_RUN ##1 state_reg != ST_RUN
			|-> hold_acknowledge_out == $past(hold_request_in) && !bus_request_out;
	endproperty
	a_hold: assert property (p_hold) else $error("hold acknowledge wrong"); // see RQ15
endmodule // rst_ctl

// ===== board_model.sv
// Board side: reset supervisor, boot strap drivers and memory reference clock
`timescale 1ns/1ns
module board_model #(
	parameter int RST_LOW_CYC = 12500
) (
	input  wire logic core_clk,
	output logic      hw_reset_n,
	output logic [3:0] boot_address_straps,
	output logic      endian_strap,
	output logic      pci_eeprom_autoinit_strap,
	output logic      host_width_strap,
	output logic      memif_ref_clock
);
	logic [1:0] div_reg = 2'h0;

	// Held low from power-up until the first pulse ends
	initial begin
		hw_reset_n = 1'b0;
		{boot_address_straps, endian_strap, pci_eeprom_autoinit_strap, host_width_strap} = 7'h00;
	end

	// Free-running memory clock, one E is four core periods
	always @(posedge core_clk) begin
		div_reg <= div_reg + 2'h1;
	end
	assign memif_ref_clock = div_reg[1];

	task automatic hw_pulse(input logic [6:0] v);
		@(posedge core_clk);
		{boot_address_straps, endian_strap, pci_eeprom_autoinit_strap, host_width_strap} <= v;
		hw_reset_n <= 1'b0;
		repeat (RST_LOW_CYC) @(posedge core_clk);
		hw_reset_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		// Straps swing away after the hold so a late relatch shows
		{boot_address_straps, endian_strap, pci_eeprom_autoinit_strap, host_width_strap} <= ~v;
	endtask
endmodule // board_model

// ===== reset_and_ext_interrupt_control_tb.sv
// Self-checking bench for the reset sequencer and interrupt detector
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module reset_and_ext_interrupt_control_tb;
	import rst_ctl_pkg::*;
	logic core_clk, sys_rst, hw_reset_n, host_soft_reset, pci_side_reset_in, pci_enable_strap;
	logic serial_port2_enable_strap, endian_strap, pci_eeprom_autoinit_strap, host_width_strap;
	logic memif_ref_clock, hold_request_in, core_hold_ack, core_bus_req, nmi_in;
	logic [3:0] boot_address_straps, external_irq_in, boot_address_out, irq_event, s_axi_wstrb;
	logic core_reset_out, pci_sm_reset_out, endian_out, pci_eeprom_autoinit_out, host_width_out;
	logic memif_clock_synced, memif_group_oe, hold_acknowledge_out, bus_request_out;
	logic eeprom_select_oe, eeprom_pins_oe, eeprom_valid, zgroup_oe, nmi_event;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] pol, lvl;
	int fail_count, checks_done, seed, k, i, e;
	int exp_irq[4], got_irq[4], exp_nmi, got_nmi;

	rst_ctl dut_u (
		.core_clk(core_clk), .sys_rst(sys_rst), .hw_reset_n(hw_reset_n),
		.host_soft_reset(host_soft_reset), .pci_side_reset_in(pci_side_reset_in),
		.pci_enable_strap(pci_enable_strap),
		.serial_port2_enable_strap(serial_port2_enable_strap),
		.boot_address_straps(boot_address_straps), .endian_strap(endian_strap),
		.pci_eeprom_autoinit_strap(pci_eeprom_autoinit_strap),
		.host_width_strap(host_width_strap), .memif_ref_clock(memif_ref_clock),
		.hold_request_in(hold_request_in), .core_hold_ack(core_hold_ack),
		.core_bus_req(core_bus_req), .nmi_in(nmi_in), .external_irq_in(external_irq_in),
		.core_reset_out(core_reset_out), .pci_sm_reset_out(pci_sm_reset_out),
		.boot_address_out(boot_address_out), .endian_out(endian_out),
		.pci_eeprom_autoinit_out(pci_eeprom_autoinit_out), .host_width_out(host_width_out),
		.memif_clock_synced(memif_clock_synced), .memif_group_oe(memif_group_oe),
		.hold_acknowledge_out(hold_acknowledge_out), .bus_request_out(bus_request_out),
		.eeprom_select_oe(eeprom_select_oe), .eeprom_pins_oe(eeprom_pins_oe),
		.eeprom_valid(eeprom_valid), .zgroup_oe(zgroup_oe), .nmi_event(nmi_event),
		.irq_event(irq_event),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);
	board_model board_u (
		.core_clk(core_clk), .hw_reset_n(hw_reset_n),
		.boot_address_straps(boot_address_straps), .endian_strap(endian_strap),
		.pci_eeprom_autoinit_strap(pci_eeprom_autoinit_strap),
		.host_width_strap(host_width_strap), .memif_ref_clock(memif_ref_clock)
	);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (nmi_event === 1'b1) got_nmi++;
		for (int j = 0; j < 4; j++) if (irq_event[j] === 1'b1) got_irq[j]++;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		logic ta, tw, tr, done;
		done = 1'b0;
		@(posedge core_clk);
		if (wr) begin
			{s_axi_awaddr, s_axi_wdata} <= {a, wd};
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		end else begin
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'b11;
		end
		for (int n = 0; n < 100 && !done; n++) begin
			#1;
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tr = s_axi_arvalid & s_axi_arready;
			done = wr ? (s_axi_bvalid === 1'b1) : (s_axi_rvalid === 1'b1);
			rd = s_axi_rdata;
			rs = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tr) s_axi_arvalid <= 1'b0;
		end
		{s_axi_bready, s_axi_rready} <= 2'b00;
		if (!done) begin
			fail_count++;
			complete_run();
		end
	endtask

	task automatic hw_cycle(input logic [6:0] v, input logic sp2);
		int tz, te, tc, tm;
		serial_port2_enable_strap <= sp2;
		hold_request_in <= v[0];
		fork
			board_u.hw_pulse(v);
			begin
				repeat (100) @(posedge core_clk);
				#1;
				`CHK({core_reset_out, zgroup_oe, memif_group_oe, bus_request_out}, 4'h8)
				`CHK(hold_acknowledge_out, v[0])
				`CHK({eeprom_select_oe, eeprom_pins_oe}, {~sp2, ~sp2})
				`CHK(memif_clock_synced, 1'b1)
				`CHK(pci_sm_reset_out, 1'b0)
				for (e = 0; e < 20000 && hw_reset_n !== 1'b1; e++) @(posedge core_clk) #1;
				if (e == 20000) begin
					fail_count++;
					complete_run();
				end
				// Two synchroniser stages, then the capture edge
				repeat (3) @(posedge core_clk);
				#1;
				`CHK({boot_address_out, endian_out, pci_eeprom_autoinit_out, host_width_out}, v)
				{tz, te, tc, tm} = '0;
				for (e = 1; e <= 100; e++) begin
					@(posedge core_clk) #1;
					if (tz == 0 && zgroup_oe === 1'b1) tz = e;
					if (te == 0 && eeprom_valid === 1'b1) te = e;
					if (tc == 0 && core_reset_out === 1'b0) tc = e;
					if (tm == 0 && memif_group_oe === 1'b1) tm = e;
				end
				`CHK(tz inside {[2:8]}, 1'b1)
				`CHK(te inside {[1:11]}, 1'b1)
				`CHK(tc inside {[1:8]}, 1'b1)
				`CHK(tm inside {[60:88]}, 1'b1)
			end
		join
	endtask

	initial begin
		seed = 16;
		sys_rst = 1'b1;
		{host_soft_reset, pci_side_reset_in, serial_port2_enable_strap, nmi_in} = 4'h0;
		{hold_request_in, core_hold_ack, core_bus_req, external_irq_in, lvl} = '0;
		pci_enable_strap = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		hw_cycle(7'h5a, 1'b0);
		axi(1'b0, POL_OFFSET, 0);
		`CHK({rs, rd}, {RESP_OKAY, 32'hf})
		axi(1'b0, STATUS_OFFSET, 0);
		`CHK(rd & 32'h5ff, 32'hda)
		axi(1'b0, 8'h0c, 0);
		`CHK(rs, RESP_SLVERR)
		axi(1'b1, 8'h0c, 32'h1);
		`CHK(rs, RESP_SLVERR)
		pol = 4'($random(seed));
		axi(1'b1, POL_OFFSET, {28'h0, pol});
		for (k = 0; k < 40; k++) begin
			i = ($random(seed) & 3);
			lvl[i] = ~lvl[i];
			if (lvl[i] == pol[i]) exp_irq[i]++;
			if (nmi_in == 1'b0) exp_nmi++;
			// Nine-period hold on every line, over twice the NMI minimum
			@(posedge core_clk);
			external_irq_in <= lvl;
			nmi_in <= ~nmi_in;
			repeat (8) @(posedge core_clk);
			#1;
			for (int j = 0; j < 4; j++) `CHK(got_irq[j], exp_irq[j])
			`CHK(got_nmi, exp_nmi)
		end
		@(posedge core_clk);
		{core_hold_ack, core_bus_req, pci_side_reset_in} <= {2'($random(seed)), 1'b1};
		repeat (3) @(posedge core_clk);
		#1;
		`CHK({hold_acknowledge_out, bus_request_out}, {core_hold_ack, core_bus_req})
		`CHK({pci_sm_reset_out, core_reset_out}, 2'b10)
		@(posedge core_clk);
		pci_side_reset_in <= 1'b0;
		hw_cycle(7'h25, 1'b1);
		for (k = 0; k < 2; k++) begin
			if (k == 0) begin
				@(posedge core_clk);
				host_soft_reset <= 1'b1;
				@(posedge core_clk);
				host_soft_reset <= 1'b0;
			end else axi(1'b1, CTRL_OFFSET, 32'h1);
			for (e = 0; e < 8 && core_reset_out !== 1'b1; e++) @(posedge core_clk) #1;
			`CHK(core_reset_out, 1'b1)
			for (e = 0; e < 80 && core_reset_out !== 1'b0; e++) @(posedge core_clk) #1;
			`CHK(e inside {[16:79]}, 1'b1)
			`CHK({boot_address_out, endian_out, pci_eeprom_autoinit_out, host_width_out}, 7'h25)
		end
		complete_run();
	end
endmodule // reset_and_ext_interrupt_control_tb
